//--- logic/adcsc_pkg.sv
/*
  Constants for the converter sequence control block: register offsets,
  field positions, reset values and conversion timing.
  Assumes a 40 MHz system clock and an AXI4-Lite register bus.
*/
package adcsc_pkg;
  localparam logic [7:0] ADCSC_OFF_MASK = 8'h00;
  localparam logic [7:0] ADCSC_OFF_CTRL = 8'h04;
  localparam logic [7:0] ADCSC_OFF_SEQ = 8'h08;
  localparam logic [7:0] ADCSC_OFF_EXTRA = 8'h0C;
  localparam logic [7:0] ADCSC_OFF_RESL = 8'h10;
  localparam logic [7:0] ADCSC_OFF_RESH = 8'h14;
  localparam logic [7:0] ADCSC_OFF_STAT = 8'h18;
  // field positions in control register
  localparam int ADCSC_CTRL_DONE = 7;
  localparam int ADCSC_CTRL_START = 6;
  localparam int ADCSC_CTRL_SSEL_LO = 4;
  // field positions in sequence and extra registers
  localparam int ADCSC_CFG_REF_LO = 6;
  localparam int ADCSC_CFG_DEC_LO = 4;
  localparam logic [7:0] ADCSC_MASK_RST = 8'h00;
  localparam logic [1:0] ADCSC_SSEL_RST = 2'h3;
  localparam logic [7:0] ADCSC_SEQ_RST = 8'h00;
  localparam logic [1:0] ADCSC_SSEL_PIN = 2'h0;
  localparam logic [1:0] ADCSC_SSEL_CHAIN = 2'h1;
  localparam logic [1:0] ADCSC_SSEL_TIMER = 2'h2;
  localparam logic [1:0] ADCSC_SSEL_SOFT = 2'h3;
  localparam logic [3:0] ADCSC_CH_DIFF = 4'h8;
  localparam logic [3:0] ADCSC_CH_INT = 4'hC;
  localparam logic [3:0] ADCSC_CH_LAST_SE6 = 4'h5;
  localparam logic [3:0] ADCSC_CH_LAST_DIFF6 = 4'hA;
  localparam logic [1:0] ADCSC_RESP_OKAY = 2'h0;
  localparam logic [1:0] ADCSC_RESP_SLVERR = 2'h2;
  // converter clock and settling
  localparam int ADCSC_CLK_DIV = 6;
  localparam logic [2:0] ADCSC_DIV_LAST = 3'(ADCSC_CLK_DIV - 1);
  localparam logic [9:0] ADCSC_SETTLE_CLKS = 10'h010;
  localparam logic [9:0] ADCSC_DEC_64 = 10'h040;
  typedef enum logic [1:0] {
    ADCSC_IDLE = 2'b00,
    ADCSC_SETTLE_CONV = 2'b01,
    ADCSC_NEXT = 2'b10
  } adcsc_state_type;
endpackage : adcsc_pkg

//--- logic/adcsc_top.sv
/*
  Sequence and extra-conversion control of a delta-sigma converter with
  an AXI4-Lite register slave, result capture and DMA trigger strobes.
  Assumes the modulator core delivers a 12-bit two's complement sample
  at the end of each conversion, and that bus inputs are synchronous to aclk.
*/
`timescale 1ns/100ps
// Behaviour
// - a pin reaches the multiplexer only if its enable mask bit is 1
// - sequence skips disabled inputs; pairs need both pins enabled
// - differential pairs are fixed: 0/1, 2/3, 4/5, 6/7
// - channel codes: 0-7 single, 8-B pairs, C-F internal sources
// - single-ended sequence runs from input 0 to the named input
// - differential sequence runs from pair 0/1 to the named pair
// - internal source codes give one conversion only
// - done flag sets at conversion end, clears on high byte read
// - software start needs select 11 and idle; bit clears at end
// - start select picks pin edge, chain, timer compare or software
// - reference field chooses positive reference for sequence
// - decimation field sets rate, resolution and conversion time
// - extra write converts now, or right after a running sequence
// - extra register holds own channel, reference and decimation
// - with no pins enabled, a sequence's readback and done still update
// - sequence results are reachable by DMA without the processor
// - a DMA trigger pulses at the end of each sequence conversion, not extra ones
// - six-pin variant supports inputs 0 through 5 only
// - multiplexer also offers temperature sensor and supply third
// - conversion lasts decimation plus 16 converter clocks, clk/6
// - interrupt only on extra conversion completion
// - readback is written value plus one below C; extra sets it
// - results two's complement, left justified in high and low
module adcsc_top
  import adcsc_pkg::*;
#(
  parameter bit SIX_PIN_VARIANT = 1'b0
) (
  input wire logic aclk, // system clock
  input wire logic aresetn, // synchronous reset, active low
  input wire logic [7:0] s_axi_awaddr, // write address
  input wire logic s_axi_awvalid, // write address valid
  output logic s_axi_awready, // write address ready
  input wire logic [31:0] s_axi_wdata, // write data
  input wire logic [3:0] s_axi_wstrb, // write strobes
  input wire logic s_axi_wvalid, // write data valid
  output logic s_axi_wready, // write data ready
  output logic [1:0] s_axi_bresp, // write response
  output logic s_axi_bvalid, // write response valid
  input wire logic s_axi_bready, // write response ready
  input wire logic [7:0] s_axi_araddr, // read address
  input wire logic s_axi_arvalid, // read address valid
  output logic s_axi_arready, // read address ready
  output logic [31:0] s_axi_rdata, // read data
  output logic [1:0] s_axi_rresp, // read response
  output logic s_axi_rvalid, // read data valid
  input wire logic s_axi_rready, // read data ready
  input wire logic external_trigger_pin, // sequence start pin
  input wire logic timer_compare_event, // timer 1 channel 0 compare pulse
  input wire logic [11:0] core_sample, // sample from modulator core
  output logic [3:0] mux_select, // multiplexer channel code
  output logic [7:0] mux_pin_enable, // pins routed to the multiplexer
  output logic [1:0] core_reference, // reference to modulator core
  output logic [1:0] core_decimation, // decimation to modulator core
  output logic core_busy, // conversion in progress
  output logic converter_irq, // extra conversion done pulse
  output logic dma_trigger_any, // any sequence/single conversion pulse
  output logic [8:0] dma_trigger_chan // per-channel trigger pulse
);
  adcsc_state_type state;
  logic [7:0] analog_input_enable_mask;
  logic [1:0] start_source_select;
  logic sequence_start_request;
  logic [7:0] sequence_config_reg;
  logic [7:0] extra_conversion_reg;
  logic [7:0] result_high_byte;
  logic [7:0] result_low_byte;
  logic conv_done;
  logic extra_pending;
  logic in_extra;
  logic in_seq;
  logic [3:0] cur_ch;
  logic [3:0] last_ch;
  logic [2:0] div_cnt;
  logic [9:0] conv_cnt;
  logic pin_q;
  logic chain_start;
  logic seq_end_q;
  logic [7:0] aw_addr;
  logic aw_have;
  logic [31:0] w_data;
  logic [3:0] w_strb;
  logic w_have;
  logic [7:0] rd_addr_q;
  logic wr_fire;
  logic rd_fire;
  logic start_event;
  logic start_seq;
  logic start_extra;
  logic conv_end;
  logic usable;
  logic [3:0] last_ok;
  logic [3:0] seq_ch;
  logic [3:0] extra_ch;

  // one entry per channel code: are the needed pins enabled
  function automatic logic ch_usable(input logic [3:0] ch,
                                     input logic [7:0] mask);
    logic ok;
    ok = 1'b1;
    if (ch < ADCSC_CH_DIFF) begin
      ok = mask[ch[2:0]];
    end else if (ch < ADCSC_CH_INT) begin
      ok = mask[{ch[1:0], 1'b0}] & mask[{ch[1:0], 1'b1}];
    end
    return ok;
  endfunction : ch_usable

  // clamp the last channel of a sequence on the six-pin part
  function automatic logic [3:0] clamp_ch(input logic [3:0] ch);
    logic [3:0] r;
    r = ch;
    if (SIX_PIN_VARIANT && ch < ADCSC_CH_DIFF && ch > ADCSC_CH_LAST_SE6) begin
      r = ADCSC_CH_LAST_SE6;
    end else if (SIX_PIN_VARIANT && ch < ADCSC_CH_INT &&
                 ch > ADCSC_CH_LAST_DIFF6) begin
      r = ADCSC_CH_LAST_DIFF6;
    end
    return r;
  endfunction : clamp_ch

  // decimation code to filter length in converter clocks
  function automatic logic [9:0] dec_len(input logic [1:0] code);
    return 10'(ADCSC_DEC_64 << code);
  endfunction : dec_len

  assign seq_ch = sequence_config_reg[3:0];
  assign extra_ch = extra_conversion_reg[3:0];
  assign last_ok = clamp_ch(seq_ch);
  assign usable = ch_usable(cur_ch, analog_input_enable_mask);

  // mask gates pin routing; six-pin part never routes the top two
  assign mux_pin_enable = SIX_PIN_VARIANT ?
    (analog_input_enable_mask & 8'h3F) : analog_input_enable_mask;
  assign mux_select = cur_ch;
  assign core_busy = (state != ADCSC_IDLE);
  assign core_reference = in_extra ?
    extra_conversion_reg[ADCSC_CFG_REF_LO +: 2] :
    sequence_config_reg[ADCSC_CFG_REF_LO +: 2];
  assign core_decimation = in_extra ?
    extra_conversion_reg[ADCSC_CFG_DEC_LO +: 2] :
    sequence_config_reg[ADCSC_CFG_DEC_LO +: 2];

  always_comb begin
    case (start_source_select)
      ADCSC_SSEL_PIN: start_event = external_trigger_pin & ~pin_q;
      ADCSC_SSEL_CHAIN: start_event = chain_start;
      ADCSC_SSEL_TIMER: start_event = timer_compare_event;
      default: start_event = sequence_start_request & ~seq_end_q;
    endcase
  end

  // extra conversion has priority only once no sequence is running
  assign start_seq = (state == ADCSC_IDLE) & start_event &
                     ~extra_pending;
  assign start_extra = (state == ADCSC_IDLE) & extra_pending;
  assign conv_end = (state == ADCSC_SETTLE_CONV) && (div_cnt == ADCSC_DIV_LAST)
                    && (conv_cnt == 10'h000);

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      pin_q <= 1'b0;
    end else begin
      pin_q <= external_trigger_pin;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      state <= ADCSC_IDLE;
      cur_ch <= 4'h0;
      last_ch <= 4'h0;
      in_extra <= 1'b0;
      in_seq <= 1'b0;
      div_cnt <= 3'h0;
      conv_cnt <= 10'h000;
      seq_end_q <= 1'b0;
    end else begin
      seq_end_q <= 1'b0;
      case (state)
        ADCSC_IDLE: begin
          div_cnt <= 3'h0;
          if (start_extra) begin
            cur_ch <= extra_ch;
            in_extra <= 1'b1;
            in_seq <= 1'b0;
            state <= ADCSC_NEXT;
          end else if (start_seq) begin
            // internal codes convert once; others walk from 0 or pair 0/1
            cur_ch <= (seq_ch >= ADCSC_CH_INT) ? seq_ch :
                      ((seq_ch >= ADCSC_CH_DIFF) ? ADCSC_CH_DIFF : 4'h0);
            last_ch <= last_ok;
            in_extra <= 1'b0;
            in_seq <= 1'b1;
            state <= ADCSC_NEXT;
          end
        end
        ADCSC_NEXT: begin
          if (usable) begin
            conv_cnt <= dec_len(core_decimation) + ADCSC_SETTLE_CLKS
                        - 10'h001;
            div_cnt <= 3'h0;
            state <= ADCSC_SETTLE_CONV;
          end else if (in_seq && cur_ch != last_ch) begin
            cur_ch <= cur_ch + 4'h1;
          end else begin
            // skipped to the end: a sequence's readback still moves as if converted
            seq_end_q <= in_seq;
            state <= ADCSC_IDLE;
          end
        end
        ADCSC_SETTLE_CONV: begin
          div_cnt <= (div_cnt == ADCSC_DIV_LAST) ? 3'h0 : div_cnt + 3'h1;
          if (div_cnt == ADCSC_DIV_LAST) begin
            conv_cnt <= conv_cnt - 10'h001;
          end
          if (conv_end) begin
            if (in_seq && cur_ch != last_ch) begin
              cur_ch <= cur_ch + 4'h1;
              state <= ADCSC_NEXT;
            end else begin
              seq_end_q <= in_seq;
              state <= ADCSC_IDLE;
            end
          end
        end
        default: state <= ADCSC_IDLE;
      endcase
    end
  end

  // end of a sequence may restart it when chaining is selected
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      chain_start <= 1'b0;
    end else begin
      chain_start <= seq_end_q;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      result_high_byte <= 8'h00;
      result_low_byte <= 8'h00;
    end else if (conv_end) begin
      result_high_byte <= core_sample[11:4];
      result_low_byte <= {core_sample[3:0], 4'h0};
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      converter_irq <= 1'b0;
      dma_trigger_any <= 1'b0;
      dma_trigger_chan <= 9'h000;
    end else begin
      converter_irq <= conv_end & in_extra;
      dma_trigger_any <= conv_end & ~in_extra;
      dma_trigger_chan <= 9'h000;
      if (conv_end && !in_extra) begin
        dma_trigger_chan[(cur_ch > 4'h8) ? 4'h8 : cur_ch] <= 1'b1;
      end
    end
  end

  // AXI4-Lite write side
  assign s_axi_awready = ~aw_have & ~s_axi_bvalid;
  assign s_axi_wready = ~w_have & ~s_axi_bvalid;
  assign wr_fire = aw_have & w_have & ~s_axi_bvalid;

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      aw_have <= 1'b0;
      w_have <= 1'b0;
      aw_addr <= 8'h00;
      w_data <= 32'h0000_0000;
      w_strb <= 4'h0;
      s_axi_bvalid <= 1'b0;
      s_axi_bresp <= ADCSC_RESP_OKAY;
    end else begin
      if (s_axi_awvalid && s_axi_awready) begin
        aw_have <= 1'b1;
        aw_addr <= s_axi_awaddr;
      end
      if (s_axi_wvalid && s_axi_wready) begin
        w_have <= 1'b1;
        w_data <= s_axi_wdata;
        w_strb <= s_axi_wstrb;
      end
      if (wr_fire) begin
        aw_have <= 1'b0;
        w_have <= 1'b0;
        s_axi_bvalid <= 1'b1;
        if (aw_addr == ADCSC_OFF_MASK || aw_addr == ADCSC_OFF_CTRL ||
            aw_addr == ADCSC_OFF_SEQ || aw_addr == ADCSC_OFF_EXTRA ||
            aw_addr == ADCSC_OFF_RESL || aw_addr == ADCSC_OFF_RESH ||
            aw_addr == ADCSC_OFF_STAT) begin
          s_axi_bresp <= ADCSC_RESP_OKAY;
        end else begin
          s_axi_bresp <= ADCSC_RESP_SLVERR;
        end
      end else if (s_axi_bvalid && s_axi_bready) begin
        s_axi_bvalid <= 1'b0;
      end
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      analog_input_enable_mask <= ADCSC_MASK_RST;
      start_source_select <= ADCSC_SSEL_RST;
      extra_conversion_reg <= ADCSC_SEQ_RST;
    end else if (wr_fire && w_strb[0]) begin
      if (aw_addr == ADCSC_OFF_MASK) begin
        analog_input_enable_mask <= w_data[7:0];
      end else if (aw_addr == ADCSC_OFF_CTRL) begin
        start_source_select <= w_data[ADCSC_CTRL_SSEL_LO +: 2];
      end else if (aw_addr == ADCSC_OFF_EXTRA) begin
        extra_conversion_reg <= w_data[7:0];
      end
    end
  end

  // sequence register: software writes, hardware updates the readback
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      sequence_config_reg <= ADCSC_SEQ_RST;
    end else if (wr_fire && w_strb[0] && aw_addr == ADCSC_OFF_SEQ) begin
      sequence_config_reg <= w_data[7:0];
    end else if (conv_end && in_extra) begin
      sequence_config_reg[3:0] <= extra_ch;
    end else if (seq_end_q && seq_ch < ADCSC_CH_INT) begin
      sequence_config_reg[3:0] <= seq_ch + 4'h1;
    end
  end

  // start bit reads as one until the sequence completes
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      sequence_start_request <= 1'b0;
    end else if (wr_fire && w_strb[0] && aw_addr == ADCSC_OFF_CTRL &&
                 w_data[ADCSC_CTRL_START] &&
                 start_source_select == ADCSC_SSEL_SOFT) begin
      sequence_start_request <= 1'b1;
    end else if (seq_end_q) begin
      sequence_start_request <= 1'b0;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      extra_pending <= 1'b0;
    end else if (wr_fire && w_strb[0] && aw_addr == ADCSC_OFF_EXTRA) begin
      extra_pending <= 1'b1;
    end else if (start_extra) begin
      extra_pending <= 1'b0;
    end
  end

  // a read of the high byte clears done; a new end wins the same cycle
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      conv_done <= 1'b0;
    end else if (conv_end || seq_end_q) begin
      conv_done <= 1'b1;
    end else if (rd_fire && s_axi_araddr == ADCSC_OFF_RESH) begin
      conv_done <= 1'b0;
    end
  end

  // AXI4-Lite read side
  assign s_axi_arready = ~s_axi_rvalid;
  assign rd_fire = s_axi_arvalid & s_axi_arready;

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_rvalid <= 1'b0;
      s_axi_rdata <= 32'h0000_0000;
      s_axi_rresp <= ADCSC_RESP_OKAY;
      rd_addr_q <= 8'h00;
    end else if (rd_fire) begin
      s_axi_rvalid <= 1'b1;
      rd_addr_q <= s_axi_araddr;
      s_axi_rresp <= ADCSC_RESP_OKAY;
      if (s_axi_araddr == ADCSC_OFF_MASK) begin
        s_axi_rdata <= {24'h000000, analog_input_enable_mask};
      end else if (s_axi_araddr == ADCSC_OFF_CTRL) begin
        s_axi_rdata <= {24'h000000, conv_done, sequence_start_request,
                        start_source_select, 4'h0};
      end else if (s_axi_araddr == ADCSC_OFF_SEQ) begin
        s_axi_rdata <= {24'h000000, sequence_config_reg};
      end else if (s_axi_araddr == ADCSC_OFF_EXTRA) begin
        s_axi_rdata <= {24'h000000, extra_conversion_reg};
      end else if (s_axi_araddr == ADCSC_OFF_RESL) begin
        s_axi_rdata <= {24'h000000, result_low_byte};
      end else if (s_axi_araddr == ADCSC_OFF_RESH) begin
        s_axi_rdata <= {24'h000000, result_high_byte};
      end else if (s_axi_araddr == ADCSC_OFF_STAT) begin
        s_axi_rdata <= {24'h000000, 2'h0, state, cur_ch};
      end else begin
        s_axi_rdata <= 32'h0000_0000;
        s_axi_rresp <= ADCSC_RESP_SLVERR;
      end
    end else if (s_axi_rvalid && s_axi_rready) begin
      s_axi_rvalid <= 1'b0;
    end
  end
endmodule : adcsc_top

//--- testbench/adcsc_top_monitor.sv
/*
  Checker for the converter sequence control: DMA trigger and interrupt
  pulses against the channel and busy outputs.
  Assumes one clock, aclk, and the synchronous active-low reset aresetn.
*/
`timescale 1ns/100ps
module adcsc_top_monitor (
  input wire logic aclk, // system clock
  input wire logic aresetn, // synchronous reset, active low
  input wire logic core_busy, // conversion in progress
  input wire logic [3:0] mux_select, // channel code being converted
  input wire logic [7:0] mux_pin_enable, // pins routed to multiplexer
  input wire logic converter_irq, // extra conversion done pulse
  input wire logic dma_trigger_any, // any sequence conversion trigger, not extra
  input wire logic [8:0] dma_trigger_chan // per-channel trigger
);
  default clocking cb @(posedge aclk);
  endclocking
  default disable iff (!aresetn);
  a_trig_onehot: assert property (
    dma_trigger_any |-> $onehot(dma_trigger_chan))
    else $error("trigger without exactly one channel bit");
  a_chan_has_any: assert property (
    (|dma_trigger_chan) |-> dma_trigger_any)
    else $error("channel trigger without the common trigger");
  a_skip_disabled: assert property (
    dma_trigger_any && !dma_trigger_chan[8]
      |-> (dma_trigger_chan[7:0] & mux_pin_enable) != 8'h00)
    else $error("trigger for a pin that is not enabled");
  a_trig_at_end: assert property (
    dma_trigger_any |-> $past(core_busy) || $past(core_busy, 2))
    else $error("trigger not at the end of a conversion");
  a_trig_matches_mux: assert property (
    dma_trigger_any && !dma_trigger_chan[8]
      |-> dma_trigger_chan[7:0] == (8'h01 << $past(mux_select, 4)))
    else $error("trigger channel differs from converted channel");
  a_irq_no_dma: assert property (
    converter_irq |-> !dma_trigger_any)
    else $error("extra conversion raised a DMA trigger");
  a_irq_pulse: assert property (
    converter_irq |=> !converter_irq)
    else $error("interrupt pulse longer than one cycle");
  a_irq_conv_time: assert property (
    converter_irq |-> $past(core_busy, 480))
    else $error("extra conversion shorter than the minimum time");
  c_diff_trig: cover property (dma_trigger_any && dma_trigger_chan[8]);
  c_pin_trig: cover property (dma_trigger_any && dma_trigger_chan[3]);
  c_extra_irq: cover property (converter_irq);
endmodule : adcsc_top_monitor

bind adcsc_top adcsc_top_monitor u_monitor (
  .aclk(aclk),
  .aresetn(aresetn),
  .core_busy(core_busy),
  .mux_select(mux_select),
  .mux_pin_enable(mux_pin_enable),
  .converter_irq(converter_irq),
  .dma_trigger_any(dma_trigger_any),
  .dma_trigger_chan(dma_trigger_chan)
);

//--- testbench/adcsc_core_model.sv
/*
  Behavioural modulator core: returns a sample that names the channel.
  Assumes the sample is only meaningful while the converter is busy.
*/
`timescale 1ns/100ps
module adcsc_core_model (
  input wire logic aclk, // system clock
  input wire logic core_busy, // conversion in progress
  input wire logic [3:0] mux_select, // channel being converted
  output logic [11:0] core_sample // 12-bit two's complement sample
);
  logic [11:0] idle_pat = 12'h000;
  // outside a conversion the output churns so a stale capture shows up
  always @(posedge aclk) idle_pat <= idle_pat + 12'h001;
  assign core_sample = core_busy ? {mux_select, 8'hA5} : ~idle_pat;
endmodule : adcsc_core_model

//--- testbench/test_adcsc_top.sv
/*
  Register-level testbench of the converter sequence control.
  Assumes AXI4-Lite answers within 50 cycles and a 40 MHz clock.
*/
`timescale 1ns/100ps
module test_adcsc_top;
  import adcsc_pkg::*;
  logic aclk, aresetn, s_axi_awvalid, s_axi_awready, s_axi_wvalid;
  logic s_axi_wready, s_axi_bvalid, s_axi_bready, s_axi_arvalid;
  logic s_axi_arready, s_axi_rvalid, s_axi_rready, external_trigger_pin;
  logic timer_compare_event, core_busy, converter_irq, dma_trigger_any;
  logic [7:0] s_axi_awaddr, s_axi_araddr, mux_pin_enable;
  logic [31:0] s_axi_wdata, s_axi_rdata;
  logic [1:0] s_axi_bresp, s_axi_rresp, core_reference, core_decimation;
  logic [11:0] core_sample;
  logic [3:0] mux_select;
  logic [8:0] dma_trigger_chan, trig_seen;
  logic [1:0] seen_ref, seen_dec;
  int num_errors = 0, tests_run = 0;
  int trig_cnt, irq_cnt, busy_len, cyc, trig_t, irq_t;
  logic [1:0] src_tbl [3] = '{ADCSC_SSEL_SOFT, ADCSC_SSEL_PIN,
                              ADCSC_SSEL_TIMER};

  adcsc_top dut (.aclk(aclk), .aresetn(aresetn), .s_axi_awaddr(s_axi_awaddr),
    .s_axi_awvalid(s_axi_awvalid), .s_axi_awready(s_axi_awready),
    .s_axi_wdata(s_axi_wdata), .s_axi_wstrb(4'hF),
    .s_axi_wvalid(s_axi_wvalid), .s_axi_wready(s_axi_wready),
    .s_axi_bresp(s_axi_bresp), .s_axi_bvalid(s_axi_bvalid),
    .s_axi_bready(s_axi_bready), .s_axi_araddr(s_axi_araddr),
    .s_axi_arvalid(s_axi_arvalid), .s_axi_arready(s_axi_arready),
    .s_axi_rdata(s_axi_rdata), .s_axi_rresp(s_axi_rresp),
    .s_axi_rvalid(s_axi_rvalid), .s_axi_rready(s_axi_rready),
    .external_trigger_pin(external_trigger_pin),
    .timer_compare_event(timer_compare_event), .core_sample(core_sample),
    .mux_select(mux_select), .mux_pin_enable(mux_pin_enable),
    .core_reference(core_reference), .core_decimation(core_decimation),
    .core_busy(core_busy), .converter_irq(converter_irq),
    .dma_trigger_any(dma_trigger_any), .dma_trigger_chan(dma_trigger_chan));
  adcsc_core_model core (.aclk(aclk), .core_busy(core_busy),
    .mux_select(mux_select), .core_sample(core_sample));

  initial begin
    aclk = 1'b0;
    forever #12.5 aclk = ~aclk;
  end

  // observer of the converter side, cleared per scenario
  always @(posedge aclk) begin
    cyc++;
    if (dma_trigger_any === 1'b1) begin
      trig_cnt++;
      trig_seen = trig_seen | dma_trigger_chan;
      trig_t = cyc;
    end
    if (converter_irq === 1'b1) begin
      irq_cnt++;
      irq_t = cyc;
    end
    if (core_busy === 1'b1) begin
      busy_len++;
      seen_ref = core_reference;
      seen_dec = core_decimation;
    end
  end

  task automatic give_verdict;
    if (num_errors == 0 && tests_run > 0)
      $display("DONE - PASS");
    else
      $display("DONE - FAIL");
    $finish;
  endtask : give_verdict

  task automatic check(input string what, input logic [31:0] exp,
                       input logic [31:0] got);
    tests_run++;
    if (got !== exp) begin
      $display("mismatch %s expected %h seen %h", what, exp, got);
      num_errors++;
    end
  endtask : check

  task automatic hang(input string what);
    check(what, 32'h1, 32'h0);
    give_verdict();
  endtask : hang

  task automatic clear_obs;
    trig_cnt = 0;
    irq_cnt = 0;
    busy_len = 0;
    trig_seen = 9'h000;
  endtask : clear_obs

  task automatic axi_write(input logic [7:0] a, input logic [7:0] d);
    int n;
    n = 0;
    @(posedge aclk);
    s_axi_awaddr <= a;
    s_axi_wdata <= {24'h000000, d};
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    do begin
      @(posedge aclk);
      n++;
      if (s_axi_awvalid && s_axi_awready) s_axi_awvalid <= 1'b0;
      if (s_axi_wvalid && s_axi_wready) s_axi_wvalid <= 1'b0;
      if (n > 50) hang("write response");
    end while (s_axi_bvalid !== 1'b1);
    s_axi_bready <= 1'b0;
  endtask : axi_write

  task automatic axi_read(input logic [7:0] a, output logic [31:0] d,
                          output logic [1:0] r);
    int n;
    n = 0;
    @(posedge aclk);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    do begin
      @(posedge aclk);
      n++;
      if (s_axi_arvalid && s_axi_arready) s_axi_arvalid <= 1'b0;
      if (n > 50) hang("read response");
    end while (s_axi_rvalid !== 1'b1);
    d = s_axi_rdata;
    r = s_axi_rresp;
    s_axi_rready <= 1'b0;
  endtask : axi_read

  task automatic rd_check(input string what, input logic [7:0] a,
                          input logic [31:0] exp);
    logic [31:0] d;
    logic [1:0] r;
    axi_read(a, d, r);
    check(what, exp, d);
  endtask : rd_check

  // a start is not always followed by a visible busy gap, so wait on events
  task automatic wait_idle(input int events);
    int n;
    n = 0;
    repeat (3) @(posedge aclk);
    while (core_busy !== 1'b0 || trig_cnt + irq_cnt < events) begin
      @(posedge aclk);
      n++;
      if (n > 8000) hang("conversion end");
    end
  endtask : wait_idle

  initial begin
    logic [31:0] d;
    logic [1:0] r;
    int lim;
    aresetn = 1'b0;
    {s_axi_awvalid, s_axi_wvalid, s_axi_bready} = 3'h0;
    {s_axi_arvalid, s_axi_rready} = 2'h0;
    {external_trigger_pin, timer_compare_event} = 2'h0;
    {s_axi_awaddr, s_axi_araddr} = 16'h0000;
    s_axi_wdata = 32'h00000000;
    clear_obs();
    repeat (12) @(posedge aclk);
    aresetn <= 1'b1;
    rd_check("mask reset", ADCSC_OFF_MASK, 32'h00);
    rd_check("control reset", ADCSC_OFF_CTRL, 32'h30);
    check("pin enable reset", 32'h00, {24'h0, mux_pin_enable});
    axi_read(8'h1C, d, r);
    check("unmapped response", {30'h0, ADCSC_RESP_SLVERR}, {30'h0, r});
    check("unmapped data", 32'h0, d);
    axi_write(ADCSC_OFF_MASK, 8'h0B);
    check("pin enable", 32'h0B, {24'h0, mux_pin_enable});
    axi_write(ADCSC_OFF_SEQ, 8'h03);
    clear_obs();
    axi_write(ADCSC_OFF_CTRL, 8'h70);
    rd_check("start while running", ADCSC_OFF_CTRL, 32'h70);
    axi_write(ADCSC_OFF_CTRL, 8'h70);
    wait_idle(3);
    repeat (600) @(posedge aclk);
    check("single count", 3, trig_cnt);
    check("single chans", 32'h00B, {23'h0, trig_seen});
    check("seq irq", 0, irq_cnt);
    rd_check("done set", ADCSC_OFF_CTRL, 32'hB0);
    rd_check("single readback", ADCSC_OFF_SEQ, 32'h04);
    rd_check("result low", ADCSC_OFF_RESL, 32'h50);
    rd_check("result high", ADCSC_OFF_RESH, 32'h3A);
    rd_check("done cleared", ADCSC_OFF_CTRL, 32'h30);
    axi_write(ADCSC_OFF_MASK, 8'h37);
    axi_write(ADCSC_OFF_SEQ, 8'h1A);
    clear_obs();
    axi_write(ADCSC_OFF_CTRL, 8'h70);
    wait_idle(2);
    check("pair count", 2, trig_cnt);
    check("pair chans", 32'h100, {23'h0, trig_seen});
    check("pair decimation", 1, seen_dec);
    rd_check("pair readback", ADCSC_OFF_SEQ, 32'h1B);
    rd_check("pair high", ADCSC_OFF_RESH, 32'hAA);
    for (int k = 0; k < 3; k++) begin
      d = {24'h000000, 2'(k), 2'(k), 4'hC + 4'(k)};
      axi_write(ADCSC_OFF_SEQ, d[7:0]);
      axi_write(ADCSC_OFF_CTRL, {2'b00, src_tbl[k], 4'h0});
      clear_obs();
      if (k == 0) axi_write(ADCSC_OFF_CTRL, 8'h70);
      @(posedge aclk);
      external_trigger_pin <= (k == 1);
      timer_compare_event <= (k == 2);
      @(posedge aclk);
      timer_compare_event <= 1'b0;
      @(posedge aclk);
      external_trigger_pin <= 1'b0;
      wait_idle(1);
      lim = ((64 << k) + 16) * ADCSC_CLK_DIV;
      check("source count", 1, trig_cnt);
      check("source chans", 32'h100, {23'h0, trig_seen});
      check("reference", k, seen_ref);
      check("decimation", k, seen_dec);
      check("conv time", 1, busy_len >= lim && busy_len <= lim + 3);
      rd_check("source readback", ADCSC_OFF_SEQ, d);
    end
    axi_write(ADCSC_OFF_SEQ, 8'h0F);
    axi_write(ADCSC_OFF_CTRL, 8'h30);
    clear_obs();
    axi_write(ADCSC_OFF_CTRL, 8'h70);
    axi_write(ADCSC_OFF_CTRL, 8'h10);
    wait_idle(1);
    axi_write(ADCSC_OFF_CTRL, 8'h30);
    wait_idle(2);
    check("chained count", 2, trig_cnt);
    clear_obs();
    axi_write(ADCSC_OFF_EXTRA, 8'h4D);
    wait_idle(1);
    check("extra irq", 1, irq_cnt);
    check("extra trig", 0, trig_cnt);
    check("extra reference", 1, seen_ref);
    rd_check("extra readback", ADCSC_OFF_SEQ, 32'h0D);
    axi_write(ADCSC_OFF_MASK, 8'h01);
    axi_write(ADCSC_OFF_SEQ, 8'h00);
    clear_obs();
    axi_write(ADCSC_OFF_CTRL, 8'h70);
    axi_write(ADCSC_OFF_EXTRA, 8'h40);
    wait_idle(2);
    check("queued irq", 1, irq_cnt);
    check("queued order", 1, trig_cnt == 1 && trig_t < irq_t);
    rd_check("queued readback", ADCSC_OFF_SEQ, 32'h00);
    axi_write(ADCSC_OFF_MASK, 8'h00);
    axi_write(ADCSC_OFF_SEQ, 8'h02);
    axi_read(ADCSC_OFF_RESH, d, r);
    axi_write(ADCSC_OFF_CTRL, 8'h70);
    wait_idle(0);
    rd_check("empty done", ADCSC_OFF_CTRL, 32'hB0);
    rd_check("empty readback", ADCSC_OFF_SEQ, 32'h03);
    give_verdict();
  end
endmodule : test_adcsc_top
